// *** asr_consts.svh ***
/*
 Offsets, field positions, reset values and timing counts of the bus address
 and soft reset registers. Assumes nothing beyond being included by name.
*/
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

`define ASR_OFS_ADDR_CFG     8'h00
`define ASR_OFS_RESET_CTL    8'h01
`define ASR_ADDR_HI          7
`define ASR_ADDR_LO          1
`define ASR_SRC_SEL_BIT      0
`define ASR_FULL_RST_BIT     1
`define ASR_LOGIC_RST_BIT    0
`define ASR_RESET_CTL_RST    8'h00
`define ASR_SRC_SEL_RST      1'b0
`define ASR_RST_PULSE_NS     20
`define ASR_CLK_PERIOD_NS    5
`define ASR_RST_PULSE_CYC    ((`ASR_RST_PULSE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)

`endif

// *** asr_pkg.sv ***
/*
 Types shared by the address select and soft reset block.
 Assumes asr_consts.svh is compiled alongside.
*/
package asr_pkg;
   typedef enum logic [1:0] {
      ASR_IDLE,
      ASR_PULSE
   } asr_rst_state_t;

   typedef enum logic [1:0] {
      ASR_GNT_NONE,
      ASR_GNT_LOCAL,
      ASR_GNT_REMOTE
   } asr_grant_t;
endpackage : asr_pkg

// *** asr_arbiter.sv ***
/*
 Two-master register access arbiter: local and remote requesters, one grant.
 Assumes requests are levels held until the one-cycle done pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module asr_arbiter
   import asr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       local_req,
   input  wire logic       remote_req,
   input  wire logic       done,
   output logic            grant_local,
   output logic            grant_remote
);

   typedef struct packed {
      asr_grant_t owner;
      logic       last_remote;
   } asr_arb_state_t;

   asr_arb_state_t s_q;
   asr_arb_state_t s_d;

   // Owner held until done, so a read or write is never split between masters
   always_comb begin
      s_d = s_q;
      unique case (s_q.owner)
         ASR_GNT_NONE: begin
            if (local_req && (!remote_req || s_q.last_remote)) begin
               s_d.owner = ASR_GNT_LOCAL; // see RL7
            end else if (remote_req) begin
               s_d.owner = ASR_GNT_REMOTE; // see RL7
            end
         end
         ASR_GNT_LOCAL, ASR_GNT_REMOTE: begin
            if (done) begin
               s_d.last_remote = (s_q.owner == ASR_GNT_REMOTE);
               s_d.owner       = ASR_GNT_NONE;
            end
         end
         default: s_d.owner = ASR_GNT_NONE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{owner: ASR_GNT_NONE, last_remote: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign grant_local  = (s_q.owner == ASR_GNT_LOCAL);
   assign grant_remote = (s_q.owner == ASR_GNT_REMOTE);

endmodule : asr_arbiter
`default_nettype wire

// *** asr_address_select_soft_reset.sv ***
/*
 Bus address register with strap or override source, and the soft reset
 control register with two self-clearing reset bits. Two register ports
 (local and remote masters) share one arbitrated access path, so a read
 never sees half of a write from the other master.
 The address strap passes a three-stage synchroniser, is captured once
 after power-on reset and then kept; the full soft reset restores that copy.
 Assumes the address strap pin is static after power-up and the I2C slave
 front ends hold a request until its done pulse, then drop it for at
 least one cycle. The soft reset outputs are decoded from the pulse state,
 so logic that uses them as asynchronous resets should resynchronise them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"

// How it works
// RL1 - Address register bits 7-1 hold target address, defaulting to strap value.
// RL2 - Address bit 0 selects source: 0 strap address, 1 programmed override.
// RL3 - Reset bit 1 resets all logic and registers, then clears itself.
// RL4 - Full reset reloads strap-defaulted registers from the captured strap value.
// RL5 - Reset bit 0 resets logic but keeps register contents, then clears itself.
// RL6 - Reset register at offset 0x1, reset 0x0, upper six bits read zero.
// RL7 - Local and remote simultaneous accesses are arbitrated without corruption.
// RL8 - Reset bits self-clear within a few cycles and read back as 0.
module asr_address_select_soft_reset
   import asr_pkg::*;
#(
   parameter int ADDR_W = 7,
   parameter int PULSE_CYC = `ASR_RST_PULSE_CYC
) (
   // Clock and power-on reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Strap level, asynchronous to clk
   input  wire logic [ADDR_W-1:0] address_strap_pin,
   // Local master register port
   input  wire logic              loc_req,
   input  wire logic              loc_we,
   input  wire logic [7:0]        loc_addr,
   input  wire logic [7:0]        loc_wdata,
   output logic [7:0]             loc_rdata,
   output logic                   loc_done,
   // Remote master register port
   input  wire logic              rem_req,
   input  wire logic              rem_we,
   input  wire logic [7:0]        rem_addr,
   input  wire logic [7:0]        rem_wdata,
   output logic [7:0]             rem_rdata,
   output logic                   rem_done,
   // Effective address and soft reset controls
   output logic [ADDR_W-1:0]      i2c_target_address,
   output logic                   logic_reset_n,
   output logic                   regs_reset_n
);

   // Elaboration checks: the byte layout fixes the address width, and the
   // four-bit pulse counter cannot hold more than fifteen cycles
   if (ADDR_W != `ASR_ADDR_HI - `ASR_ADDR_LO + 1) begin : g_bad_addr_w
      $error("ADDR_W must match the address field of the register");
   end
   if (PULSE_CYC < 1 || PULSE_CYC > 15) begin : g_bad_pulse
      $error("PULSE_CYC must lie between 1 and 15");
   end

   // All state of the block outside the arbiter: one comb copy, one register
   typedef struct packed {
      // Strap synchroniser, fill count and captured copy
      logic [1:0]        strap_fill;
      logic [ADDR_W-1:0] strap_s1;
      logic [ADDR_W-1:0] strap_s2;
      logic [ADDR_W-1:0] strap_s3;
      logic              strap_valid;
      logic [ADDR_W-1:0] strap_val;
      // Address register contents
      logic [ADDR_W-1:0] addr;
      logic              src_sel;
      // Soft reset pulse
      asr_rst_state_t    rst_state;
      logic              rst_full;
      logic [3:0]        rst_cnt;
      // Access answer
      logic              done;
      logic              done_remote;
      logic [7:0]        rdata;
   } asr_state_t;

   // Registered state and its next value
   asr_state_t s_q;
   asr_state_t s_d;
   // Grants and the granted master's access
   logic       grant_local;
   logic       grant_remote;
   logic       acc_we;
   logic [7:0] acc_addr;
   logic [7:0] acc_wdata;

   // Readback mux shared by both masters; unmapped offsets read as zero
   function automatic logic [7:0] read_reg(input logic [7:0] ofs, input asr_state_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (ofs)
         `ASR_OFS_ADDR_CFG: begin
            v = {s.addr, s.src_sel}; // see RL1, RL2
         end
         `ASR_OFS_RESET_CTL: begin
            // Reset bits always read 0: they live only as the pulse state
            v = `ASR_RESET_CTL_RST; // see RL6, RL8
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction : read_reg

   // Write strobe decode for one offset, shared by both registers
   function automatic logic write_hit(input logic we, input logic [7:0] a, input logic [7:0] ofs);
      logic hit;
      hit = we && (a == ofs);
      return hit;
   endfunction : write_hit

   // One owner from grant to done; a tie goes to the master that did not
   // win the last access, so neither port can starve the other
   asr_arbiter u_arb (
      .clk          (clk),
      .reset_n      (reset_n),
      .local_req    (loc_req),
      .remote_req   (rem_req),
      .done         (s_q.done),
      .grant_local  (grant_local),
      .grant_remote (grant_remote)
   );

   // Selected master's access; one owner at a time. With no grant the
   // remote port shows through, which is harmless as no access then runs
   assign acc_we    = grant_local ? loc_we    : rem_we;
   assign acc_addr  = grant_local ? loc_addr  : rem_addr;
   assign acc_wdata = grant_local ? loc_wdata : rem_wdata; // see RL7

   // Next state: strap capture, register access, then the reset pulse,
   // which comes last so that its restore wins over anything else
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      // Strap synchroniser: value captured once, when stages two and three agree
      s_d.strap_s1 = address_strap_pin;
      s_d.strap_s2 = s_q.strap_s1;
      s_d.strap_s3 = s_q.strap_s2;
      // Stage three holds a pin sample only three edges after reset; the
      // fill count keeps the reset zeros from being taken as the strap
      if (s_q.strap_fill != 2'h3) begin
         s_d.strap_fill = s_q.strap_fill + 2'h1;
      end
      if (!s_q.strap_valid && s_q.strap_fill == 2'h3 && s_q.strap_s2 == s_q.strap_s3) begin
         s_d.strap_valid = 1'b1;
         s_d.strap_val   = s_q.strap_s3;
         s_d.addr        = s_q.strap_s3; // see RL1
      end
      // Access cycle: granted request is served once, answered next cycle.
      // Held off until the strap is known, so an early write is not lost
      if ((grant_local || grant_remote) && !s_q.done && s_q.rst_state == ASR_IDLE && s_q.strap_valid) begin
         s_d.done        = 1'b1;
         s_d.done_remote = grant_remote;
         s_d.rdata       = read_reg(acc_addr, s_q);
         if (write_hit(acc_we, acc_addr, `ASR_OFS_ADDR_CFG)) begin
            s_d.addr    = acc_wdata[`ASR_ADDR_HI:`ASR_ADDR_LO]; // see RL1
            s_d.src_sel = acc_wdata[`ASR_SRC_SEL_BIT];        // see RL2
         end
         // Bit 1 has priority: writing both bits gives the full reset
         if (write_hit(acc_we, acc_addr, `ASR_OFS_RESET_CTL)) begin
            if (acc_wdata[`ASR_FULL_RST_BIT]) begin
               s_d.rst_state = ASR_PULSE;
               s_d.rst_full  = 1'b1; // see RL3
               s_d.rst_cnt   = 4'(PULSE_CYC);
            end else if (acc_wdata[`ASR_LOGIC_RST_BIT]) begin
               s_d.rst_state = ASR_PULSE;
               s_d.rst_full  = 1'b0; // see RL5
               s_d.rst_cnt   = 4'(PULSE_CYC);
            end
         end
      end
      // Self-clearing pulse; the full variant reloads the registers in every pulse cycle,
      // so they hold their reset values from the second pulse cycle on, the logic-only one leaves them
      unique case (s_q.rst_state)
         ASR_IDLE: ;
         ASR_PULSE: begin
            if (s_q.rst_full) begin
               s_d.addr    = s_q.strap_val;       // see RL4
               s_d.src_sel = `ASR_SRC_SEL_RST;    // see RL3
            end
            // Count down; the last pulse cycle returns to idle
            s_d.rst_cnt = s_q.rst_cnt - 4'h1;
            if (s_q.rst_cnt == 4'h1) begin
               s_d.rst_state = ASR_IDLE; // see RL8
               s_d.rst_full  = 1'b0;
            end
         end
         default: s_d.rst_state = ASR_IDLE;
      endcase
   end

   // State register; power-on reset clears all, the strap copy included
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{rst_state: ASR_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Override only after the strap is known; before that the strap copy is 0.
   // Read data is one register for both ports: it stands until the next
   // access of either master, so each master takes it with its done pulse
   assign i2c_target_address = s_q.src_sel ? s_q.addr : s_q.strap_val; // see RL2
   assign logic_reset_n      = !(s_q.rst_state == ASR_PULSE);          // see RL3, RL5
   assign regs_reset_n       = !(s_q.rst_state == ASR_PULSE && s_q.rst_full); // see RL3
   assign loc_done           = s_q.done && !s_q.done_remote;
   assign rem_done           = s_q.done && s_q.done_remote;
   assign loc_rdata          = s_q.rdata;
   assign rem_rdata          = s_q.rdata;

endmodule : asr_address_select_soft_reset
`default_nettype wire

// *** asr_sva.sv ***
/*
 Checker for the address select and soft reset block.
 Assumes the default PULSE_CYC of 4 and a strap that changes only in reset.
*/
`timescale 1ns/1ps
`default_nettype none
module asr_sva #(
   parameter int ADDR_W = 7
) (
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic [ADDR_W-1:0] address_strap_pin,
   input wire logic              loc_req,
   input wire logic              loc_we,
   input wire logic [7:0]        loc_addr,
   input wire logic [7:0]        loc_rdata,
   input wire logic              loc_done,
   input wire logic              rem_done,
   input wire logic [ADDR_W-1:0] i2c_target_address,
   input wire logic              logic_reset_n,
   input wire logic              regs_reset_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Read-back of the address byte must agree with the live address
   AST_ADDR_SRC: assert property (loc_done && !loc_we && loc_addr == 8'h00 |->
      i2c_target_address == (loc_rdata[0] ? loc_rdata[7:1] : address_strap_pin)) else $error("address source");
   AST_RST_RD0: assert property (loc_done && !loc_we && loc_addr == 8'h01 |-> loc_rdata == 8'h00)
      else $error("reset reg not zero");
   // Pulses self-clear after exactly four cycles
   AST_FULL_PULSE: assert property ($fell(regs_reset_n) |-> !regs_reset_n [*4] ##1 regs_reset_n)
      else $error("full pulse length");
   AST_LOGIC_PULSE: assert property ($fell(logic_reset_n) |-> !logic_reset_n [*4] ##1 logic_reset_n)
      else $error("logic pulse length");
   AST_FULL_IMPL: assert property (!regs_reset_n |-> !logic_reset_n) else $error("full without logic");
   // A logic-only pulse leaves the address register untouched
   AST_KEEP: assert property (!logic_reset_n && regs_reset_n |-> $stable(i2c_target_address))
      else $error("registers lost on logic reset");
   AST_RESTORE: assert property ($rose(regs_reset_n) |=> i2c_target_address == address_strap_pin)
      else $error("strap not restored");
   // One shared path, so never two completions at once
   AST_DONE_EXCL: assert property (!(loc_done && rem_done)) else $error("double done");
   AST_DONE_CAUSE: assert property (loc_done |-> $past(loc_req, 2) && !$past(loc_done))
      else $error("done without request");
endmodule : asr_sva
bind asr_address_select_soft_reset asr_sva #(.ADDR_W(ADDR_W)) u_sva (.clk, .reset_n, .address_strap_pin,
   .loc_req, .loc_we, .loc_addr, .loc_rdata, .loc_done, .rem_done, .i2c_target_address, .logic_reset_n,
   .regs_reset_n);
`default_nettype wire

// *** asr_host.sv ***
/*
 Register master model for one access port, local or remote.
 Assumes the block answers with a one-cycle done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module asr_host (
   input  wire logic       clk,
   input  wire logic       done,
   input  wire logic [7:0] rdata,
   output var  logic       req,
   output var  logic       we,
   output var  logic [7:0] addr,
   output var  logic [7:0] wdata
);
   // Transfers that never saw done; the bench counts them as mismatches
   int n_timeouts = 0;
   // Idle at time zero
   initial {req, we, addr, wdata} = '0;
   // One byte access, held until the done edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(negedge clk);
      {req, we, addr, wdata} = {1'b1, w, a, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 40);
      if (done !== 1'b1) n_timeouts++;
      q = rdata;
      @(negedge clk);
      {req, we, addr, wdata} = {1'b0, ~w, ~a, ~d}; // Stale values inverted, not left showing
   endtask : xfer
endmodule : asr_host
`default_nettype wire

// *** address_select_soft_reset_test.sv ***
/*
 Self-checking bench for the address select and soft reset block.
 Assumes asr_host models drive both register ports.
*/
`timescale 1ns/1ps
`default_nettype none
module address_select_soft_reset_test;
   typedef struct packed {logic w; logic [7:0] a, d, rd; logic [6:0] ta;} asr_row_t;
   logic       clk, reset_n, loc_req, loc_we, loc_done, rem_req, rem_we, rem_done, lrn, rrn, sl, sr;
   logic [7:0] loc_addr, loc_wdata, loc_rdata, rem_addr, rem_wdata, rem_rdata, q, q2;
   logic [6:0] ta, strap;
   int         fail_count, n_checks;
   // Write, offset, data, expected read, expected address
   asr_row_t   rows [10] = '{'{0, 8'h00, 8'h00, 8'h58, 7'h2C}, '{0, 8'h01, 8'h00, 8'h00, 7'h2C},
      '{1, 8'h00, 8'hA5, 8'h00, 7'h52}, '{0, 8'h00, 8'h00, 8'hA5, 7'h52}, '{1, 8'h00, 8'hA4, 8'h00, 7'h2C},
      '{0, 8'h00, 8'h00, 8'hA4, 7'h2C}, '{1, 8'h37, 8'hFF, 8'h00, 7'h2C}, '{0, 8'h37, 8'h00, 8'h00, 7'h2C},
      '{1, 8'h01, 8'hFC, 8'h00, 7'h2C}, '{0, 8'h01, 8'h00, 8'h00, 7'h2C}};
   asr_address_select_soft_reset dut (.clk(clk), .reset_n(reset_n), .address_strap_pin(strap),
      .loc_req(loc_req), .loc_we(loc_we), .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_rdata(loc_rdata),
      .loc_done(loc_done), .rem_req(rem_req), .rem_we(rem_we), .rem_addr(rem_addr), .rem_wdata(rem_wdata),
      .rem_rdata(rem_rdata), .rem_done(rem_done), .i2c_target_address(ta), .logic_reset_n(lrn),
      .regs_reset_n(rrn));
   asr_host h_loc (.clk(clk), .done(loc_done), .rdata(loc_rdata), .req(loc_req), .we(loc_we),
      .addr(loc_addr), .wdata(loc_wdata));
   asr_host h_rem (.clk(clk), .done(rem_done), .rdata(rem_rdata), .req(rem_req), .we(rem_we),
      .addr(rem_addr), .wdata(rem_wdata));
   always #2.5 clk = ~clk;
   // Latch any soft reset pulse seen
   always @(posedge clk) begin
      if (lrn === 1'b0) sl <= 1'b1;
      if (rrn === 1'b0) sr <= 1'b1;
   end
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic conclude();
      fail_count += h_loc.n_timeouts + h_rem.n_timeouts; // Hung transfers count as mismatches
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // Watchdog, far beyond the hundred-odd cycles needed
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
   initial begin
      {clk, reset_n, sl, sr, fail_count, n_checks} = '0;
      strap = 7'h2C;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("reset outs", {6'h00, lrn, rrn}, 8'h03);
      foreach (rows[i]) begin
         h_loc.xfer(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) chk("rdata", q, rows[i].rd);
         chk("address", {1'b0, ta}, {1'b0, rows[i].ta});
      end
      $display("table done");
      h_loc.xfer(1'b1, 8'h00, 8'hA5, q);
      h_loc.xfer(1'b1, 8'h01, 8'h01, q);
      h_loc.xfer(1'b0, 8'h00, 8'h00, q);
      chk("kept", q, 8'hA5);
      chk("logic pulse", {6'h00, sl, sr}, 8'h02);
      {sl, sr} = 2'b00;
      h_loc.xfer(1'b1, 8'h01, 8'h03, q);
      h_loc.xfer(1'b0, 8'h00, 8'h00, q);
      chk("restored", q, 8'h58);
      chk("full pulse", {6'h00, sl, sr}, 8'h03);
      h_loc.xfer(1'b0, 8'h01, 8'h00, q);
      chk("self clear", q, 8'h00);
      $display("soft reset done");
      // Both masters at the same edge
      fork
         h_loc.xfer(1'b1, 8'h00, 8'h5B, q);
         h_rem.xfer(1'b0, 8'h00, 8'h00, q2);
      join
      chk("race read", {7'h00, q2 === 8'h58 || q2 === 8'h5B}, 8'h01);
      h_rem.xfer(1'b1, 8'h00, 8'h6D, q2);
      h_loc.xfer(1'b0, 8'h00, 8'h00, q);
      chk("remote write", q, 8'h6D);
      chk("remote addr", {1'b0, ta}, 8'h36);
      $display("arbitration done");
      // Mid-run power-on reset with a new strap: override dropped, strap taken afresh
      reset_n = 1'b0;
      strap   = 7'h15;
      repeat (3) @(negedge clk);
      chk("reset addr", {1'b0, ta}, 8'h00);
      reset_n = 1'b1;
      h_loc.xfer(1'b0, 8'h00, 8'h00, q);
      chk("new strap", q, 8'h2A);
      chk("new addr", {1'b0, ta}, 8'h15);
      $display("power reset done");
      conclude();
   end
endmodule : address_select_soft_reset_test
`default_nettype wire
